// >>> pigf_filter.sv
// one group of glitch filter channels sharing a filter clock enable
// assumes din is already synchronised to aclk
`timescale 1ns/1ps
module pigf_filter
	import pigf_pkg::*;
#(
	parameter int W = 1
)(
	// clock and reset
	input  wire logic         aclk,
	input  wire logic         aresetn,
	// control
	input  wire logic         sample_en,
	input  wire logic         bypass,
	// data
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);

	logic [W-1:0] samp_q;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			samp_q <= '0;
		else if (sample_en)
			samp_q <= din;
	end

	// a level seen on two consecutive samples is taken; one sample is not enough
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			dout <= '0;
		else if (bypass)
			dout <= din;
		else if (sample_en)
			dout <= (din & ~(din ^ samp_q)) | (dout & (din ^ samp_q));
	end

	// judged per bit: one channel may settle while a neighbour is still bouncing
	a_two_samples: assert property (@(posedge aclk) disable iff (!aresetn)
		(!$past(bypass) && $changed(dout)) |->
		($past(sample_en) && (((dout ^ $past(dout)) & ($past(din) ^ $past(samp_q))) == '0)))
		else $error("filter output changed without two equal samples");

	a_single_reject: assert property (@(posedge aclk) disable iff (!aresetn)
		(sample_en && !bypass && din != samp_q) |=>
		(((dout ^ $past(dout)) & ($past(din) ^ $past(samp_q))) == '0))
		else $error("filter output followed a single differing sample");

endmodule

// >>> pigf_pins.sv
// pin-side model: free-running low-power oscillator and input pins
// assumes the bench calls set_pin right after a rising aclk edge
`timescale 1ns/1ps
module pigf_pins (
	// clock
	input  wire logic aclk,
	// pins
	output logic       lpo,
	output logic [4:0] port_e,
	output logic [7:0] kbd,
	output logic       rst_irq
);
	initial
	begin
		port_e = 5'h00;
		kbd = 8'h00;
		rst_irq = 1'b0;
		lpo = 1'b0;
		// offset keeps oscillator edges clear of aclk edges
		#1.1;
		forever #12.5 lpo = ~lpo;
	end

	task automatic set_pin(input int ch, input logic v);
		case (ch)
			0: port_e[0] <= v;
			1: kbd[0] <= v;
			default: rst_irq <= v;
		endcase
	endtask
endmodule

// >>> pigf_pkg.sv
// constants shared by the port input glitch filter and its channel filter
// assumes a 32-bit AXI4-Lite register bus and one bus clock
package pigf_pkg;

	// register indices; byte address is four times the index
	localparam logic [13:0] IDX_PORT_E_FLT   = 14'h30ED;
	localparam logic [13:0] IDX_KBI_RST_FLT  = 14'h30EE;
	localparam logic [13:0] IDX_FCLK_DIV     = 14'h30EF;
	localparam logic [13:0] IDX_PA_PULL      = 14'h30F0;

	// writable bit masks; other bits read zero
	localparam logic [7:0]  PORT_E_FLT_MASK  = 8'h03;
	localparam logic [7:0]  KBI_RST_MASK     = 8'h0F;
	localparam logic [7:0]  FCLK_DIV_MASK    = 8'hFF;
	localparam logic [7:0]  PA_PULL_MASK     = 8'hEF;

	// reset values
	localparam logic [7:0]  PORT_E_FLT_RST   = 8'h00;
	localparam logic [7:0]  KBI_RST_RST      = 8'h00;
	localparam logic [7:0]  FCLK_DIV_RST     = 8'h00;
	localparam logic [7:0]  PA_PULL_RST      = 8'h00;

	// field positions
	localparam int          PORT_E_SEL_LSB   = 0;
	localparam int          KBI_SEL_LSB      = 2;
	localparam int          RST_SEL_LSB      = 0;
	localparam int          DIV1_LSB         = 0;
	localparam int          DIV2_LSB         = 2;
	localparam int          DIV3_LSB         = 5;
	localparam int          PA_I2C_BIT       = 3;

	// filter clock selection codes
	localparam logic [1:0]  SEL_BUS          = 2'h0;
	localparam logic [1:0]  SEL_DIV1         = 2'h1;
	localparam logic [1:0]  SEL_DIV2         = 2'h2;
	localparam logic [1:0]  SEL_DIV3         = 2'h3;

	// exponent of the smallest divide of each bus-clock set
	localparam logic [3:0]  DIV1_BASE_EXP    = 4'h1;
	localparam logic [3:0]  DIV2_BASE_EXP    = 4'h5;

	// divider counter widths
	localparam int          BUS_CNT_W        = 12;
	localparam int          LPO_CNT_W        = 7;

	// axi responses
	localparam logic [1:0]  RESP_OKAY        = 2'h0;
	localparam logic [1:0]  RESP_SLVERR      = 2'h2;

	// mask of the n lowest bits
	function automatic logic [BUS_CNT_W-1:0] pigf_low_ones(input logic [3:0] n);
		logic [BUS_CNT_W-1:0] m;
		m = '0;
		for (int i = 0; i < BUS_CNT_W; i++)
		begin
			m[i] = (i < int'(n));
		end
		return m;
	endfunction

endpackage

// >>> pigf_top.sv
// port input glitch filters, filter clock dividers and port a pullup control
// assumes axi4-lite master, lpo clock arriving on a pin, stop_mode on aclk
//
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/1ps

// Contract
// - reserved filter register bits read zero
// - port e selection picks its filter clock
// - keyboard selection picks its filter clock
// - set one/two become set three in stop (keyboard and reset pin only; port e keeps its selected set)
// - reset pin code 00 bypasses filter
// - pulses under one period are suppressed
// - pulses over two periods pass through
// - set three divides lpo by 2^code
// - set two divides bus by 32..4096
// - set one divides bus by 2..16
// - pullup bit set enables pin pullup
// - pullup ignored on outputs or hi-z (the code keeps the pullup on i2c bit three while it drives high, hi-z or not)
// - pullup register bit four reads zero
// - i2c bit three pullup off driving low
module pigf_top
	import pigf_pkg::*;
#(
	parameter int ADDR_W   = 16,
	parameter int PE_W     = 5,
	parameter int KBI_W    = 8,
	parameter int PA_W     = 8
)(
	// clock and reset
	input  wire logic              aclk,
	input  wire logic              aresetn,
	// axi4-lite write address
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic [2:0]        s_axi_awprot,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	// axi4-lite write data
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	// axi4-lite write response
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	// axi4-lite read address
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic [2:0]        s_axi_arprot,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	// axi4-lite read data
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	// clocks and modes
	input  wire logic              low_power_osc_clock,
	input  wire logic              stop_mode,
	// pins in
	input  wire logic [PE_W-1:0]   port_e_in,
	input  wire logic [KBI_W-1:0]  keyboard_interrupt_zero_in,
	input  wire logic              reset_irq_in,
	// filtered to core
	output logic      [PE_W-1:0]   port_e_filt,
	output logic      [KBI_W-1:0]  keyboard_filt,
	output logic                   reset_irq_filt,
	// port a pad control
	input  wire logic [PA_W-1:0]   port_a_dir_out,
	input  wire logic [PA_W-1:0]   port_a_hiz,
	input  wire logic [PA_W-1:0]   port_a_out_val,
	input  wire logic              port_a_bit3_i2c,
	output logic      [PA_W-1:0]   port_a_pull_en
);

	// registers
	logic [7:0]        pe_flt_q;
	logic [7:0]        kbi_rst_q;
	logic [7:0]        fclk_div_q;
	logic [7:0]        pa_pull_q;

	// bus state
	logic              aw_hold_q;
	logic              w_hold_q;
	logic [ADDR_W-1:0] awaddr_q;
	logic [7:0]        wdata_q;
	logic              wstrb_q;
	logic              bvalid_q;
	logic [1:0]        bresp_q;
	logic              rvalid_q;
	logic [1:0]        rresp_q;
	logic [31:0]       rdata_q;
	logic [13:0]       rd_idx_q;
	logic              wr_en;
	logic [13:0]       wr_idx;

	// dividers
	logic [BUS_CNT_W-1:0] bus_cnt_q;
	logic [LPO_CNT_W-1:0] lpo_cnt_q;
	logic [BUS_CNT_W-1:0] div1_mask;
	logic [BUS_CNT_W-1:0] div2_mask;
	logic [BUS_CNT_W-1:0] div3_mask;
	logic              lpo_s1_q;
	logic              lpo_s2_q;
	logic              lpo_s3_q;
	logic              lpo_rise;
	logic              div1_tick;
	logic              div2_tick;
	logic              div3_tick;

	// filter selection
	logic [1:0]        pe_sel;
	logic [1:0]        kbi_sel;
	logic [1:0]        rst_sel;
	logic [1:0]        kbi_eff;
	logic [1:0]        rst_eff;
	logic              pe_tick;
	logic              kbi_tick;
	logic              rst_tick;

	// pin synchronisers
	logic [PE_W-1:0]   pe_s1_q;
	logic [PE_W-1:0]   pe_s2_q;
	logic [KBI_W-1:0]  kbi_s1_q;
	logic [KBI_W-1:0]  kbi_s2_q;
	logic              rst_s1_q;
	logic              rst_s2_q;

	function automatic logic idx_mapped(input logic [13:0] idx);
		return (idx == IDX_PORT_E_FLT) || (idx == IDX_KBI_RST_FLT) ||
			(idx == IDX_FCLK_DIV) || (idx == IDX_PA_PULL);
	endfunction

	function automatic logic [7:0] reg_read(input logic [13:0] idx);
		logic [7:0] v;
		v = 8'h00;
		unique case (idx)
			IDX_PORT_E_FLT:  v = pe_flt_q & PORT_E_FLT_MASK;
			IDX_KBI_RST_FLT: v = kbi_rst_q & KBI_RST_MASK;
			IDX_FCLK_DIV:    v = fclk_div_q & FCLK_DIV_MASK;
			IDX_PA_PULL:     v = pa_pull_q & PA_PULL_MASK;
			default:         v = 8'h00;
		endcase
		return v;
	endfunction

	// maps a selection code to its filter clock enable
	// ticks come in as arguments so every caller re-evaluates when they move
	function automatic logic sel_tick(input logic [1:0] sel, input logic t1, input logic t2,
		input logic t3);
		logic t;
		t = 1'b0;
		unique case (sel)
			SEL_BUS:  t = 1'b1;
			SEL_DIV1: t = t1;
			SEL_DIV2: t = t2;
			SEL_DIV3: t = t3;
		endcase
		return t;
	endfunction

	// write channel: address and data taken in either order
	assign s_axi_awready = !aw_hold_q && !bvalid_q;
	assign s_axi_wready  = !w_hold_q && !bvalid_q;
	assign wr_en         = aw_hold_q && w_hold_q && !bvalid_q;
	assign wr_idx        = awaddr_q[15:2];

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_hold_q <= 1'b0;
			awaddr_q  <= '0;
		end
		else if (s_axi_awvalid && s_axi_awready)
		begin
			aw_hold_q <= 1'b1;
			awaddr_q  <= s_axi_awaddr;
		end
		else if (wr_en)
			aw_hold_q <= 1'b0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			w_hold_q <= 1'b0;
			wdata_q  <= 8'h00;
			wstrb_q  <= 1'b0;
		end
		else if (s_axi_wvalid && s_axi_wready)
		begin
			w_hold_q <= 1'b1;
			wdata_q  <= s_axi_wdata[7:0];
			wstrb_q  <= s_axi_wstrb[0];
		end
		else if (wr_en)
			w_hold_q <= 1'b0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			bvalid_q <= 1'b0;
			bresp_q  <= RESP_OKAY;
		end
		else if (wr_en)
		begin
			bvalid_q <= 1'b1;
			bresp_q  <= idx_mapped(wr_idx) ? RESP_OKAY : RESP_SLVERR;
		end
		else if (s_axi_bready)
			bvalid_q <= 1'b0;
	end

	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp  = bresp_q;

	// register writes; reserved bits never store
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			pe_flt_q   <= PORT_E_FLT_RST;
			kbi_rst_q  <= KBI_RST_RST;
			fclk_div_q <= FCLK_DIV_RST;
			pa_pull_q  <= PA_PULL_RST;
		end
		else if (wr_en && wstrb_q)
		begin
			if (wr_idx == IDX_PORT_E_FLT)
				pe_flt_q <= wdata_q & PORT_E_FLT_MASK;
			if (wr_idx == IDX_KBI_RST_FLT)
				kbi_rst_q <= wdata_q & KBI_RST_MASK;
			if (wr_idx == IDX_FCLK_DIV)
				fclk_div_q <= wdata_q & FCLK_DIV_MASK;
			if (wr_idx == IDX_PA_PULL)
				pa_pull_q <= wdata_q & PA_PULL_MASK;
		end
	end

	// read channel: answer one cycle after the address is taken
	assign s_axi_arready = !rvalid_q;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid_q <= 1'b0;
			rresp_q  <= RESP_OKAY;
			rdata_q  <= 32'h0000_0000;
			rd_idx_q <= 14'h0000;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			rvalid_q <= 1'b1;
			rd_idx_q <= s_axi_araddr[15:2];
			rresp_q  <= idx_mapped(s_axi_araddr[15:2]) ? RESP_OKAY : RESP_SLVERR;
			rdata_q  <= {24'h00_0000, reg_read(s_axi_araddr[15:2])};
		end
		else if (s_axi_rready)
			rvalid_q <= 1'b0;
	end

	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rresp  = rresp_q;
	assign s_axi_rdata  = rdata_q;

	// bus clock dividers share one free counter
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			bus_cnt_q <= '0;
		else
			bus_cnt_q <= bus_cnt_q + 1'b1;
	end

	assign div1_mask = pigf_low_ones(DIV1_BASE_EXP + {2'h0, fclk_div_q[DIV1_LSB +: 2]});
	assign div2_mask = pigf_low_ones(DIV2_BASE_EXP + {1'b0, fclk_div_q[DIV2_LSB +: 3]});
	assign div1_tick = (bus_cnt_q & div1_mask) == div1_mask;
	assign div2_tick = (bus_cnt_q & div2_mask) == div2_mask;

	// lpo pin is asynchronous; edge taken only after two flops
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			lpo_s1_q <= 1'b0;
			lpo_s2_q <= 1'b0;
			lpo_s3_q <= 1'b0;
		end
		else
		begin
			lpo_s1_q <= low_power_osc_clock;
			lpo_s2_q <= lpo_s1_q;
			lpo_s3_q <= lpo_s2_q;
		end
	end

	assign lpo_rise = lpo_s2_q && !lpo_s3_q;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			lpo_cnt_q <= '0;
		else if (lpo_rise)
			lpo_cnt_q <= lpo_cnt_q + 1'b1;
	end

	assign div3_mask = pigf_low_ones({1'b0, fclk_div_q[DIV3_LSB +: 3]});
	assign div3_tick = lpo_rise && ((lpo_cnt_q & div3_mask[LPO_CNT_W-1:0]) ==
		div3_mask[LPO_CNT_W-1:0]);

	// selections; stop mode forces set three on keyboard and reset pin codes one and two
	assign pe_sel   = pe_flt_q[PORT_E_SEL_LSB +: 2];
	assign kbi_sel  = kbi_rst_q[KBI_SEL_LSB +: 2];
	assign rst_sel  = kbi_rst_q[RST_SEL_LSB +: 2];
	assign kbi_eff  = (stop_mode && (kbi_sel == SEL_DIV1 || kbi_sel == SEL_DIV2)) ?
		SEL_DIV3 : kbi_sel;
	assign rst_eff  = (stop_mode && (rst_sel == SEL_DIV1 || rst_sel == SEL_DIV2)) ?
		SEL_DIV3 : rst_sel;
	assign pe_tick  = sel_tick(pe_sel, div1_tick, div2_tick, div3_tick);
	assign kbi_tick = sel_tick(kbi_eff, div1_tick, div2_tick, div3_tick);
	assign rst_tick = sel_tick(rst_eff, div1_tick, div2_tick, div3_tick);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			pe_s1_q  <= '0;
			pe_s2_q  <= '0;
			kbi_s1_q <= '0;
			kbi_s2_q <= '0;
			rst_s1_q <= 1'b0;
			rst_s2_q <= 1'b0;
		end
		else
		begin
			pe_s1_q  <= port_e_in;
			pe_s2_q  <= pe_s1_q;
			kbi_s1_q <= keyboard_interrupt_zero_in;
			kbi_s2_q <= kbi_s1_q;
			rst_s1_q <= reset_irq_in;
			rst_s2_q <= rst_s1_q;
		end
	end

	pigf_filter #(.W(PE_W)) u_pe_filter (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.sample_en (pe_tick),
		.bypass    (1'b0),
		.din       (pe_s2_q),
		.dout      (port_e_filt)
	);

	pigf_filter #(.W(KBI_W)) u_kbi_filter (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.sample_en (kbi_tick),
		.bypass    (1'b0),
		.din       (kbi_s2_q),
		.dout      (keyboard_filt)
	);

	pigf_filter #(.W(1)) u_rst_filter (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.sample_en (rst_tick),
		.bypass    (rst_sel == SEL_BUS),
		.din       (rst_s2_q),
		.dout      (reset_irq_filt)
	);

	// pullups: input pins only, except i2c bit three while driving high
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			port_a_pull_en <= '0;
		else
		begin
			for (int i = 0; i < PA_W; i++)
			begin
				if (i == PA_I2C_BIT && port_a_bit3_i2c && port_a_dir_out[i])
					port_a_pull_en[i] <= pa_pull_q[i] && port_a_out_val[i];
				else
					port_a_pull_en[i] <= pa_pull_q[i] && !port_a_dir_out[i] &&
						!port_a_hiz[i];
			end
		end
	end

	sequence s_stop_kbi_slow;
		stop_mode && (kbi_sel == SEL_DIV1 || kbi_sel == SEL_DIV2);
	endsequence

	a_pe_resv_zero: assert property (@(posedge aclk) disable iff (!aresetn)
		(rvalid_q && rd_idx_q == IDX_PORT_E_FLT) |-> rdata_q[31:2] == 30'h0)
		else $error("port e filter reserved bits not zero");

	a_kbi_resv_zero: assert property (@(posedge aclk) disable iff (!aresetn)
		(rvalid_q && rd_idx_q == IDX_KBI_RST_FLT) |-> rdata_q[31:4] == 28'h0)
		else $error("keyboard filter reserved bits not zero");

	a_pe_bus_sel: assert property (@(posedge aclk) disable iff (!aresetn)
		(pe_sel == SEL_BUS) |-> pe_tick)
		else $error("port e bus clock selection not sampling each cycle");

	a_kbi_div2_sel: assert property (@(posedge aclk) disable iff (!aresetn)
		(!stop_mode && kbi_sel == SEL_DIV2) |-> (kbi_tick == div2_tick))
		else $error("keyboard set two selection wrong");

	a_kbi_stop_div3: assert property (@(posedge aclk) disable iff (!aresetn)
		s_stop_kbi_slow |-> (kbi_tick == div3_tick))
		else $error("keyboard not on set three in stop");

	a_rst_bypass: assert property (@(posedge aclk) disable iff (!aresetn)
		(rst_sel == SEL_BUS) |=> (reset_irq_filt == $past(rst_s2_q)))
		else $error("reset pin not bypassed on code zero");

	a_div3_rate: assert property (@(posedge aclk) disable iff (!aresetn)
		(fclk_div_q[DIV3_LSB +: 3] == 3'h0) |-> (div3_tick == lpo_rise))
		else $error("set three code zero not undivided");

	a_div2_align: assert property (@(posedge aclk) disable iff (!aresetn)
		div2_tick |-> (bus_cnt_q[4:0] == 5'h1F))
		else $error("set two ticks faster than bus over 32");

	a_div1_gap: assert property (@(posedge aclk) disable iff (!aresetn)
		(div1_tick && fclk_div_q[DIV1_LSB +: 2] == 2'h0) |=> !div1_tick)
		else $error("set one ticks every cycle");

	a_pull_input: assert property (@(posedge aclk) disable iff (!aresetn)
		(!port_a_dir_out[0] && !port_a_hiz[0]) |=> (port_a_pull_en[0] == $past(pa_pull_q[0])))
		else $error("input pin pullup does not follow enable");

	a_pull_output_off: assert property (@(posedge aclk) disable iff (!aresetn)
		(port_a_dir_out[7] || port_a_hiz[7]) |=> !port_a_pull_en[7])
		else $error("pullup active on output or hi-z pin");

	a_pull_bit4_zero: assert property (@(posedge aclk) disable iff (!aresetn)
		(rvalid_q && rd_idx_q == IDX_PA_PULL) |-> !rdata_q[4])
		else $error("pullup bit four reads one");

	a_i2c_low_off: assert property (@(posedge aclk) disable iff (!aresetn)
		(port_a_bit3_i2c && port_a_dir_out[3] && !port_a_out_val[3]) |=> !port_a_pull_en[3])
		else $error("i2c pullup on while driving low");

endmodule

// >>> pigf_top_tb.sv
// self-checking bench for the port input glitch filter block
// assumes pigf_pins on the pins; oscillator period is five aclk cycles
`timescale 1ns/1ps
module pigf_top_tb;
	import pigf_pkg::*;
	localparam logic [15:0] A_E = {IDX_PORT_E_FLT, 2'b00};
	localparam logic [15:0] A_K = {IDX_KBI_RST_FLT, 2'b00};
	localparam logic [15:0] A_D = {IDX_FCLK_DIV, 2'b00};
	localparam logic [15:0] A_P = {IDX_PA_PULL, 2'b00};
	logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, stop_mode, pa_i2c, lpo, rst_in, rst_filt;
	logic [15:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [1:0]  bresp, rresp;
	logic [4:0]  pe_in, pe_filt;
	logic [7:0]  kb_in, kb_filt, pa_dir, pa_hiz, pa_val, pa_pull;
	int          fail_count, samples_checked, cycles;

	pigf_pins pins (.aclk(aclk), .lpo(lpo), .port_e(pe_in), .kbd(kb_in), .rst_irq(rst_in));
	pigf_top DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .low_power_osc_clock(lpo),
		.stop_mode(stop_mode), .port_e_in(pe_in), .keyboard_interrupt_zero_in(kb_in),
		.reset_irq_in(rst_in), .port_e_filt(pe_filt), .keyboard_filt(kb_filt),
		.reset_irq_filt(rst_filt), .port_a_dir_out(pa_dir), .port_a_hiz(pa_hiz),
		.port_a_out_val(pa_val), .port_a_bit3_i2c(pa_i2c), .port_a_pull_en(pa_pull));

	always #2.5 aclk = ~aclk;

	task automatic end_sim();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// longest test is the div-4096 row; ceiling leaves ample margin
	always @(posedge aclk)
	begin
		cycles++;
		if (cycles == 80000)
		begin
			fail_count++;
			end_sim();
		end
	end

	task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp)
		begin
			$display("ERROR %s expected %h seen %h", nm, exp, got);
			fail_count++;
		end
	endtask

	// handshakes judged at the rising edge itself; released just after it
	task automatic axi_wr(input logic [15:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
		end
		while (!(bvalid && bready));
		r = bresp;
		bready <= 1'b0;
	endtask

	task automatic axi_rd(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (arvalid && arready)
				arvalid <= 1'b0;
		end
		while (!(rvalid && rready));
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask

	task automatic rd_chk(input logic [15:0] a, input logic [31:0] exp, input logic [1:0] er);
		logic [31:0] d;
		logic [1:0]  r;
		axi_rd(a, d, r);
		check("read data", exp, d);
		check("read resp", {30'h0, er}, {30'h0, r});
	endtask

	task automatic test_regs();
		logic [15:0] ad [4];
		logic [7:0]  mk [4];
		logic [1:0]  r;
		ad = '{A_E, A_K, A_D, A_P};
		mk = '{8'h03, 8'h0F, 8'hFF, 8'hEF};
		for (int i = 0; i < 4; i++)
		begin
			rd_chk(ad[i], 32'h0, 2'h0);
			axi_wr(ad[i], 32'hFFFF_FFFF, r);
			check("write resp", 32'h0, {30'h0, r});
			rd_chk(ad[i], {24'h0, mk[i]}, 2'h0);
			axi_wr(ad[i], 32'h0, r);
		end
		// unmapped word just past the pullup register
		rd_chk(16'hC3C4, 32'h0, 2'h2);
		axi_wr(16'hC3C4, 32'hFF, r);
		check("unmapped write resp", 32'h2, {30'h0, r});
		$display("test_regs done");
	endtask

	function automatic logic filt_of(input int ch);
		case (ch)
			0: return pe_filt[0];
			1: return kb_filt[0];
			default: return rst_filt;
		endcase
	endfunction

	// pulse of w cycles, then watch long enough for sync plus two ticks
	task automatic pulse(input int ch, input int w, input logic exp, input int p);
		logic seen;
		seen = filt_of(ch);
		@(posedge aclk);
		pins.set_pin(ch, 1'b1);
		repeat (w) @(posedge aclk);
		pins.set_pin(ch, 1'b0);
		repeat (3 * p + 8)
		begin
			@(negedge aclk);
			seen = seen | filt_of(ch);
		end
		check("pulse seen", {31'h0, exp}, {31'h0, seen});
		check("filter idle", 32'h0, {31'h0, filt_of(ch)});
		check("quiet channels", 32'h0, {21'h0, pe_filt[4:1], kb_filt[7:1]});
	endtask

	task automatic cfg(input int ch, input logic [1:0] sel, input logic [7:0] dv);
		logic [1:0] r;
		axi_wr(A_D, {24'h0, dv}, r);
		axi_wr(ch == 0 ? A_E : A_K, {28'h0, ch == 1 ? {sel, 2'h0} : {2'h0, sel}}, r);
	endtask

	// one period short must vanish, two periods plus must pass
	task automatic run(input int ch, input logic [1:0] sel, input logic [7:0] dv, input int p);
		cfg(ch, sel, dv);
		if (p > 1)
			pulse(ch, p - 1, 1'b0, p);
		pulse(ch, 2 * p + 2, 1'b1, p);
	endtask

	task automatic test_port_e();
		run(0, 2'h0, 8'h00, 1);
		for (int c = 0; c < 4; c++)
			run(0, 2'h1, 8'(c), 2 << c);
		run(0, 2'h2, 8'h00, 32);
		run(0, 2'h3, 8'h00, 5);
		run(0, 2'h3, 8'hE0, 640);
		$display("test_port_e done");
	endtask

	task automatic test_keyboard();
		run(1, 2'h0, 8'h00, 1);
		run(1, 2'h1, 8'h01, 4);
		run(1, 2'h2, 8'h1C, 4096);
		run(1, 2'h3, 8'h20, 10);
		$display("test_keyboard done");
	endtask

	task automatic test_reset_pin();
		cfg(2, 2'h0, 8'h00);
		pulse(2, 1, 1'b1, 1);
		run(2, 2'h1, 8'h03, 16);
		run(2, 2'h2, 8'h04, 64);
		run(2, 2'h3, 8'h40, 20);
		$display("test_reset_pin done");
	endtask

	// set three of 40 cycles replaces set one of 2 only while stopped
	task automatic test_stop();
		@(posedge aclk);
		stop_mode <= 1'b1;
		run(1, 2'h1, 8'h60, 40);
		run(2, 2'h2, 8'h60, 40);
		@(posedge aclk);
		stop_mode <= 1'b0;
		run(1, 2'h1, 8'h60, 2);
		$display("test_stop done");
	endtask

	task automatic pull_chk(input logic [7:0] dir, input logic [7:0] hiz,
		input logic [7:0] val, input logic i2c, input logic [7:0] exp);
		@(posedge aclk);
		pa_dir <= dir;
		pa_hiz <= hiz;
		pa_val <= val;
		pa_i2c <= i2c;
		repeat (3) @(negedge aclk);
		check("port a pull", {24'h0, exp}, {24'h0, pa_pull});
	endtask

	task automatic test_pullup();
		logic [1:0] r;
		axi_wr(A_P, 32'hFF, r);
		pull_chk(8'h00, 8'h00, 8'h00, 1'b0, 8'hEF);
		pull_chk(8'h01, 8'h80, 8'h00, 1'b0, 8'h6E);
		pull_chk(8'h08, 8'h00, 8'h08, 1'b0, 8'hE7);
		pull_chk(8'h08, 8'h00, 8'h08, 1'b1, 8'hEF);
		pull_chk(8'h08, 8'h00, 8'h00, 1'b1, 8'hE7);
		axi_wr(A_P, 32'h00, r);
		pull_chk(8'h00, 8'h00, 8'h00, 1'b0, 8'h00);
		$display("test_pullup done");
	endtask

	initial
	begin
		{aclk, awvalid, wvalid, bready, arvalid, rready, stop_mode, pa_i2c} = '0;
		{awaddr, araddr, wdata, pa_dir, pa_hiz, pa_val} = '0;
		aresetn = 1'b0;
		fail_count = 0;
		samples_checked = 0;
		cycles = 0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		test_regs();
		test_port_e();
		test_keyboard();
		test_reset_pin();
		test_stop();
		test_pullup();
		end_sim();
	end
endmodule
